// ==== gain_calib_pkg.sv ====
// constants shared by the gain and offset correction stage
package gain_calib_pkg;

  // widths
  localparam int COEF_W          = 18;
  localparam int OUT_W           = 16;
  localparam int SAMPLE_W_DEF    = 14;
  localparam int EXT_SAMPLE_W    = OUT_W + 1;
  localparam int PROD_W          = EXT_SAMPLE_W + COEF_W;
  localparam int SUM_W           = PROD_W + 1;

  // fixed point scaling of the coefficients
  localparam int MULT_FRAC       = 16;
  localparam int ADD_FRAC        = 17;
  localparam int SAMPLE_FRAC     = OUT_W - 1;
  localparam int PROD_FRAC       = SAMPLE_FRAC + MULT_FRAC;
  localparam int ADD_SHIFT       = PROD_FRAC - ADD_FRAC;
  localparam int OUT_LSB         = PROD_FRAC - SAMPLE_FRAC;

  // pipeline latency in sampling clock cycles
  localparam int LATENCY_CYCLES  = 3;

  // gain relay encoding
  localparam logic GAIN_HIGH     = 1'b1;
  localparam logic GAIN_LOW      = 1'b0;

  // static coefficient defaults: unity gain, zero offset
  localparam logic [COEF_W-1:0] MULT_UNITY = 18'h10000;
  localparam logic [COEF_W-1:0] ADD_ZERO   = 18'h00000;

endpackage

// ==== valid_delay_line.sv ====
// fixed length shift line for the sample valid strobe
`timescale 1ns/10ps
`default_nettype none

module valid_delay_line #(
  parameter int DEPTH = 3
) (
  input  wire logic sample_clk,
  input  wire logic sample_rst_low,
  input  wire logic valid_in,
  output var  logic valid_out
);

  logic [DEPTH-1:0] stage_reg;

  // every stage cleared in reset so no stale sample is flagged
  always_ff @(posedge sample_clk or negedge sample_rst_low) begin
    if (!sample_rst_low) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[DEPTH-2:0], valid_in};
    end
  end

  assign valid_out = stage_reg[DEPTH-1];

endmodule // valid_delay_line

`default_nettype wire

// ==== gain_offset_calibration.sv ====
// gain and offset correction stage for one digitizer channel
`timescale 1ns/10ps
`default_nettype none

module gain_offset_calibration #(
  parameter int                sample_resolution_param    =
    gain_calib_pkg::SAMPLE_W_DEF,
  parameter bit                external_coef_enable_param = 1'b0,
  parameter bit                sample_invert_param        = 1'b0,
  parameter logic [17:0]       static_low_gain_multiplier =
    gain_calib_pkg::MULT_UNITY,
  parameter logic [17:0]       static_low_gain_adder      =
    gain_calib_pkg::ADD_ZERO,
  parameter logic [17:0]       static_high_gain_multiplier =
    gain_calib_pkg::MULT_UNITY,
  parameter logic [17:0]       static_high_gain_adder     =
    gain_calib_pkg::ADD_ZERO
) (
  input  wire logic                               sample_clk,
  input  wire logic                               sample_rst_low,
  input  wire logic                               calib_bypass,
  input  wire logic [gain_calib_pkg::COEF_W-1:0]  ext_low_gain_multiplier,
  input  wire logic [gain_calib_pkg::COEF_W-1:0]  ext_low_gain_adder,
  input  wire logic [gain_calib_pkg::COEF_W-1:0]  ext_high_gain_multiplier,
  input  wire logic [gain_calib_pkg::COEF_W-1:0]  ext_high_gain_adder,
  input  wire logic                               gain_relay_state,
  input  wire logic [sample_resolution_param-1:0] raw_sample_in,
  input  wire logic                               raw_sample_valid,
  output var  logic [gain_calib_pkg::OUT_W-1:0]   corrected_sample_out,
  output var  logic                               corrected_sample_valid
);

  localparam int CW = gain_calib_pkg::COEF_W;
  localparam int OW = gain_calib_pkg::OUT_W;
  localparam int EW = gain_calib_pkg::EXT_SAMPLE_W;
  localparam int PW = gain_calib_pkg::PROD_W;
  localparam int SW = gain_calib_pkg::SUM_W;
  localparam int LSB = gain_calib_pkg::OUT_LSB;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [CW-1:0] pick_coef(
    input logic          relay,
    input logic [CW-1:0] low_coef,
    input logic [CW-1:0] high_coef
  );
    pick_coef = (relay == gain_calib_pkg::GAIN_HIGH) ? high_coef : low_coef;
  endfunction

  // full precision multiply-add, top 16 relevant bits kept
  function automatic logic [OW-1:0] mult_add(
    input logic signed [PW-1:0] prod,
    input logic        [CW-1:0] add_coef
  );
    logic signed [SW-1:0] add_aligned;
    logic signed [SW-1:0] sum;
    add_aligned = SW'($signed(add_coef)) <<< gain_calib_pkg::ADD_SHIFT;
    sum         = SW'(prod) + add_aligned;
    mult_add    = sum[LSB+OW-1:LSB];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // coefficient source

  logic [CW-1:0] lg_mult;
  logic [CW-1:0] lg_add;
  logic [CW-1:0] hg_mult;
  logic [CW-1:0] hg_add;

  // static parameters unless the external ports are enabled
  assign lg_mult = external_coef_enable_param ? ext_low_gain_multiplier
                                              : static_low_gain_multiplier;
  assign lg_add  = external_coef_enable_param ? ext_low_gain_adder
                                              : static_low_gain_adder;
  assign hg_mult = external_coef_enable_param ? ext_high_gain_multiplier
                                              : static_high_gain_multiplier;
  assign hg_add  = external_coef_enable_param ? ext_high_gain_adder
                                              : static_high_gain_adder;

  //////////////////////////////////////////////////////////////////////////
  // input alignment

  logic        [OW-1:0] raw_aligned;
  logic signed [EW-1:0] sample_ext;

  // msb-justify to 16 bits, a sample scaled as a signed fraction
  assign raw_aligned = OW'(raw_sample_in) << (OW - sample_resolution_param);
  assign sample_ext  = EW'($signed(raw_aligned));

  //////////////////////////////////////////////////////////////////////////
  // stage 1: sign, coefficient select

  logic signed [EW-1:0] s1_sample_reg;
  logic        [CW-1:0] s1_mult_reg;
  logic        [CW-1:0] s1_add_reg;
  logic        [OW-1:0] s1_raw_reg;
  logic                 s1_bypass_reg;

  always_ff @(posedge sample_clk or negedge sample_rst_low) begin
    if (!sample_rst_low) begin
      s1_sample_reg <= '0;
      s1_mult_reg   <= '0;
      s1_add_reg    <= '0;
      s1_raw_reg    <= '0;
      s1_bypass_reg <= 1'b0;
    end else begin
      // 17-bit so negating full scale cannot wrap
      s1_sample_reg <= sample_invert_param ? -sample_ext : sample_ext;
      s1_mult_reg   <= pick_coef(gain_relay_state, lg_mult, hg_mult);
      s1_add_reg    <= pick_coef(gain_relay_state, lg_add, hg_add);
      s1_raw_reg    <= raw_aligned;
      s1_bypass_reg <= calib_bypass;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // stage 2: multiply

  logic signed [PW-1:0] s2_prod_reg;
  logic        [CW-1:0] s2_add_reg;
  logic        [OW-1:0] s2_raw_reg;
  logic                 s2_bypass_reg;

  always_ff @(posedge sample_clk or negedge sample_rst_low) begin
    if (!sample_rst_low) begin
      s2_prod_reg   <= '0;
      s2_add_reg    <= '0;
      s2_raw_reg    <= '0;
      s2_bypass_reg <= 1'b0;
    end else begin
      // product carries 31 fraction bits
      s2_prod_reg   <= PW'(s1_sample_reg) * PW'($signed(s1_mult_reg));
      s2_add_reg    <= s1_add_reg;
      s2_raw_reg    <= s1_raw_reg;
      s2_bypass_reg <= s1_bypass_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // stage 3: add offset, select output

  always_ff @(posedge sample_clk or negedge sample_rst_low) begin
    if (!sample_rst_low) begin
      corrected_sample_out <= '0;
    end else if (s2_bypass_reg) begin
      corrected_sample_out <= s2_raw_reg;
    end else begin
      corrected_sample_out <= mult_add(s2_prod_reg, s2_add_reg);
    end
  end

  valid_delay_line #(
    .DEPTH (gain_calib_pkg::LATENCY_CYCLES)
  ) u_valid_delay (
    .sample_clk     (sample_clk),
    .sample_rst_low (sample_rst_low),
    .valid_in       (raw_sample_valid),
    .valid_out      (corrected_sample_valid)
  );

  //////////////////////////////////////////////////////////////////////////
  // checks

  logic signed [PW-1:0] chk_prod;
  logic        [OW-1:0] chk_result;

  assign chk_prod   = PW'(s1_sample_reg) * PW'($signed(s1_mult_reg));
  assign chk_result = mult_add(chk_prod, s1_add_reg);

  default clocking chk_clk @(posedge sample_clk);
  endclocking
  default disable iff (!sample_rst_low);

  a_valid_delay_set: assert property (
    sample_rst_low && raw_sample_valid |-> ##3 corrected_sample_valid)
    else $error("valid not seen three cycles after input valid");

  a_valid_delay_clr: assert property (
    !raw_sample_valid |-> ##3 !corrected_sample_valid)
    else $error("valid raised without input valid three cycles earlier");

  a_valid_reset_clr: assert property (
    $rose(sample_rst_low) |-> !corrected_sample_valid [*3])
    else $error("valid flagged before fresh data after reset");

  a_bypass_raw_out: assert property (
    sample_rst_low && calib_bypass |->
      ##3 corrected_sample_out == $past(raw_aligned, 3))
    else $error("bypass output differs from raw sample");

  a_gain_pair_sel: assert property (
    sample_rst_low |=>
      s1_mult_reg == ($past(gain_relay_state) ? $past(hg_mult)
                                               : $past(lg_mult)) &&
      s1_add_reg  == ($past(gain_relay_state) ? $past(hg_add)
                                               : $past(lg_add)))
    else $error("wrong coefficient pair for relay state");

  a_coef_source: assert property (
    external_coef_enable_param ||
    (hg_mult == static_high_gain_multiplier &&
     lg_add == static_low_gain_adder))
    else $error("static coefficients not used");

  a_ext_coef_use: assert property (
    (sample_rst_low && external_coef_enable_param && gain_relay_state) |=>
      s1_mult_reg == $past(ext_high_gain_multiplier) &&
      s1_add_reg == $past(ext_high_gain_adder))
    else $error("external coefficients not applied");

  a_sign_invert: assert property (
    sample_rst_low |=>
      s1_sample_reg == (sample_invert_param ? -$past(sample_ext)
                                            : $past(sample_ext)))
    else $error("sample sign handling wrong");

  a_calib_result: assert property (
    sample_rst_low && !s1_bypass_reg |->
      ##2 corrected_sample_out == $past(chk_result, 2))
    else $error("calibrated result mismatch");

  c_valid_through: cover property (
    raw_sample_valid ##3 corrected_sample_valid);
  c_bypass_sample: cover property (
    calib_bypass && raw_sample_valid ##3 corrected_sample_valid);
  c_high_gain: cover property (
    gain_relay_state && !calib_bypass && raw_sample_valid);
  c_gain_switch: cover property (
    $changed(gain_relay_state) && raw_sample_valid);

endmodule // gain_offset_calibration

`default_nettype wire

// ==== sample_source.sv ====
// upstream raw sample source model for the correction stage
`timescale 1ns/10ps
`default_nettype none

module sample_source (
  input  wire logic        sample_clk,
  input  wire logic        send,
  input  wire logic [13:0] send_data,
  output var  logic [13:0] raw_sample_in,
  output var  logic        raw_sample_valid
);
  logic [13:0] last_reg = 14'h0000;

  always_ff @(posedge sample_clk) begin
    if (send) begin
      last_reg <= send_data;
    end
  end

  // idle bus shows the inverted last word, never a stale copy
  always_comb begin
    raw_sample_valid = send;
    raw_sample_in    = send ? send_data : ~last_reg;
  end
endmodule // sample_source

`default_nettype wire

// ==== gain_offset_calibration_test.sv ====
// self-checking bench for the gain and offset correction stage
`timescale 1ns/10ps
`default_nettype none

module gain_offset_calibration_test;
  localparam logic [17:0] SML = 18'h0F000;
  localparam logic [17:0] SAL = 18'h00400;
  localparam logic [17:0] SMH = 18'h14000;
  localparam logic [17:0] SAH = 18'h3FC00;
  logic        sample_clk, sample_rst_low, calib_bypass, gain_relay_state;
  logic        send, raw_sample_valid, v_ext, v_st;
  logic [17:0] ml, al, mh, ah;
  logic [13:0] send_data, raw_sample_in;
  logic [15:0] d_ext, d_st;
  int          num_errors, samples_checked, cycles;

  sample_source src (.sample_clk(sample_clk), .send(send),
    .send_data(send_data), .raw_sample_in(raw_sample_in),
    .raw_sample_valid(raw_sample_valid));

  gain_offset_calibration #(.sample_resolution_param(14),
    .external_coef_enable_param(1'b1)) uut (.sample_clk(sample_clk),
    .sample_rst_low(sample_rst_low), .calib_bypass(calib_bypass),
    .ext_low_gain_multiplier(ml), .ext_low_gain_adder(al),
    .ext_high_gain_multiplier(mh), .ext_high_gain_adder(ah),
    .gain_relay_state(gain_relay_state), .raw_sample_in(raw_sample_in),
    .raw_sample_valid(raw_sample_valid), .corrected_sample_out(d_ext),
    .corrected_sample_valid(v_ext));

  gain_offset_calibration #(.sample_resolution_param(14),
    .sample_invert_param(1'b1), .static_low_gain_multiplier(SML),
    .static_low_gain_adder(SAL), .static_high_gain_multiplier(SMH),
    .static_high_gain_adder(SAH)) uut_static (.sample_clk(sample_clk),
    .sample_rst_low(sample_rst_low), .calib_bypass(calib_bypass),
    .ext_low_gain_multiplier(ml), .ext_low_gain_adder(al),
    .ext_high_gain_multiplier(mh), .ext_high_gain_adder(ah),
    .gain_relay_state(gain_relay_state), .raw_sample_in(raw_sample_in),
    .raw_sample_valid(raw_sample_valid), .corrected_sample_out(d_st),
    .corrected_sample_valid(v_st));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sample_clk = 1'b0;
    forever #5 sample_clk = ~sample_clk;
  end

  always @(posedge sample_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] expect_out(input logic [13:0] raw,
    input logic byp, input logic rel, input logic inv,
    input logic [17:0] mlo, input logic [17:0] alo,
    input logic [17:0] mhi, input logic [17:0] ahi);
    logic signed [16:0] s;
    logic signed [17:0] m, a;
    logic signed [35:0] sum;
    s = signed'({raw[13], raw, 2'b00});
    if (byp) return s[15:0];
    if (inv) s = -s;
    m = rel ? mhi : mlo;
    a = rel ? ahi : alo;
    sum = s * m + (36'(a) <<< 14);
    return sum[31:16];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  // drives n-1 samples over n slots (one gap) and compares each result 3 edges later
  task automatic run_stream(input int n, input int relay_mode);
    logic [15:0] qd[$], qs[$];
    logic        qv[$];
    logic [13:0] d;
    logic        vin, r, ev;
    for (int i = 0; i < n + 3; i++) begin
      @(posedge sample_clk);
      vin = (i < n) && (i != 3);
      d = (i == 0) ? 14'h1FFF : (i == 1) ? 14'h2000 : 14'(i * 14'h0537);
      r = relay_mode[1] ? i[0] : relay_mode[0];
      send <= vin;
      send_data <= d;
      gain_relay_state <= r;
      qv.push_back(vin);
      qd.push_back(expect_out(d, calib_bypass, r, 1'b0, ml, al, mh, ah));
      qs.push_back(expect_out(d, calib_bypass, r, 1'b1, SML, SAL, SMH, SAH));
      #1;
      if (i >= 3) begin
        ev = qv.pop_front();
        check({15'h0000, v_ext}, {15'h0000, ev});
        check({15'h0000, v_st}, {15'h0000, ev});
        if (ev) begin
          check(d_ext, qd.pop_front());
          check(d_st, qs.pop_front());
        end else begin
          void'(qd.pop_front());
          void'(qs.pop_front());
        end
      end
    end
  endtask

  task automatic scen_calibrated();
    @(posedge sample_clk);
    calib_bypass <= 1'b0;
    ml <= 18'h0E000;
    al <= 18'h3F000;
    mh <= 18'h11000;
    ah <= 18'h00C00;
    run_stream(9, 2);
    run_stream(5, 1);
  endtask

  task automatic scen_bypass();
    @(posedge sample_clk);
    calib_bypass <= 1'b1;
    run_stream(6, 0);
    @(posedge sample_clk);
    calib_bypass <= 1'b0;
  endtask

  task automatic scen_reset();
    @(posedge sample_clk);
    send <= 1'b1;
    send_data <= 14'h0ABC;
    repeat (2) @(posedge sample_clk);
    sample_rst_low <= 1'b0;
    @(posedge sample_clk);
    #1;
    check(d_ext, 16'h0000);
    check({15'h0000, v_ext}, 16'h0000);
    @(posedge sample_clk);
    sample_rst_low <= 1'b1;
    send <= 1'b0;
    repeat (4) begin
      @(posedge sample_clk);
      #1;
      check({15'h0000, v_ext | v_st}, 16'h0000);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    sample_rst_low = 1'b0;
    calib_bypass = 1'b0;
    gain_relay_state = 1'b0;
    send = 1'b0;
    send_data = 14'h0000;
    {ml, al, mh, ah} = 72'h0;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (10) @(posedge sample_clk);
    sample_rst_low <= 1'b1;
    scen_calibrated();
    scen_bypass();
    scen_reset();
    scen_calibrated();
    close_out();
  end
endmodule // gain_offset_calibration_test

`default_nettype wire
